/* hw/dual_reload_timer_pwm_capture.sv */
// 16-bit down timer with two reload/capture registers, pwm, event count and capture modes
// Functional notes
// (R01) one 16-bit down counter plus reload registers a and b (high/low time)
// (R02) pwm counts at instruction rate or fast clock; each underflow reloads
// (R03) first underflow after start reloads from a, then b, a, b alternately
// (R04) toggle pwm inverts pin a per underflow; plain pwm leaves pin a alone
// (R05) mode 101 pwm toggle, 100 pwm plain, 000 count rising, 001 count falling
// (R06) pwm underflows set pending a and b alternately; software clears them
// (R07) enable a/b allow interrupts for reloads from a/b; clear masks them
// (R08) event mode decrements on selected synchronized edge of pin a
// (R09) event mode underflow sets pending a; enable a lets it interrupt
// (R10) event mode rising pin b edge sets pending b, interrupts if enabled
// (R11) event mode drives no pwm waveform on pin a
// (R12) capture mode counts freely; pin edges copy counter into a or b
// (R13) capture codes 010 rr, 110 rf, 011 fr, 111 ff; edges chosen per pin
// (R14) capture edges set pending a and b; enables gate interrupts
// (R15) capture underflow sets run bit as pending; enable a covers it too
// (R16) software clears run bit entering capture and checks both causes
// (R17) in pwm and event modes run bit 1 starts, 0 stops the counter
// (R18) software should stop the fast timer before altering counter or regs
// (R19) control bits take any write or set/clear at any time safely
// (R20) only the second timer may count from the fast clock
// (R21) fast select bit 0 of speed register picks fast clock; resets zero
// (R22) counter and reload registers need no defined reset value
// (R23) irq a when a source for a and enable a; irq b likewise
module dual_reload_timer_pwm_capture #(
  parameter bit SECOND_TIMER = 1'b1,
  parameter int DIV = timer_pkg::TC_DIV
) (
  input wire logic mclk,
  input wire logic resetn,
  // mode select and enables, written by software as levels
  input wire logic mode_select_hi,
  input wire logic mode_select_mid,
  input wire logic mode_select_lo,
  input wire logic irq_enable_a,
  input wire logic irq_enable_b,
  input wire logic [7:0] speed_control_register,
  // single-bit set and clear strobes for hardware-set bits
  input wire logic run_set,
  input wire logic run_clear,
  input wire logic pending_a_clear,
  input wire logic pending_b_clear,
  // counter and reload register writes
  input wire logic counter_wr,
  input wire logic reload_a_wr,
  input wire logic reload_b_wr,
  input wire logic [15:0] wr_data,
  // pins
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_b,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe_n,
  // state read back
  output logic [15:0] counter_value,
  output logic [15:0] reload_capture_reg_a,
  output logic [15:0] reload_capture_reg_b,
  output logic run_or_underflow_bit,
  output logic pending_flag_a,
  output logic pending_flag_b,
  output logic irq_a,
  output logic irq_b
);

  localparam int CNT_W = timer_pkg::CNT_W;
  localparam int DIV_W = $clog2(DIV) + 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  // cycles until the pin synchronisers and edge copies hold real levels
  localparam logic [1:0] FILL_DONE = 2'h3;

  // refuse parameter values the logic cannot serve
  if (DIV < 2) begin : g_bad_div
    $error("instruction clock divider must be at least 2");
  end
  if (CNT_W != 16) begin : g_bad_width
    $error("counter must be 16 bits");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic pa_s1;
    logic pa_s2;
    logic pb_s1;
    logic pb_s2;
    logic pa_q;
    logic pb_q;
    logic [1:0] fill;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ra;
    logic [CNT_W-1:0] rb;
    logic sel_b;
    logic run;
    logic pnd_a;
    logic pnd_b;
    logic pin_out;
    logic pin_oe_n;
    logic irq_a;
    logic irq_b;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [2:0] mode;
  logic is_pwm;
  logic is_evt;
  logic is_cap;
  logic fast;
  logic tick;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic edge_a;
  logic edge_b;
  logic step;
  logic uflow;
  logic armed;

  // mode decode and counting rate
  always_comb begin
    mode = {mode_select_hi, mode_select_mid, mode_select_lo};
    is_pwm = mode_select_hi && !mode_select_mid; // R05
    is_evt = !mode_select_hi && !mode_select_mid; // R05
    is_cap = mode_select_mid; // R13
    fast = SECOND_TIMER && speed_control_register[timer_pkg::FAST_SEL_POS]; // R20 R21
    tick = fast || (st_r.div == '0); // R02
    armed = (st_r.fill == FILL_DONE);
    a_rise = tick && armed && st_r.pa_s2 && !st_r.pa_q; // R08
    a_fall = tick && armed && !st_r.pa_s2 && st_r.pa_q;
    b_rise = tick && armed && st_r.pb_s2 && !st_r.pb_q;
    b_fall = tick && armed && !st_r.pb_s2 && st_r.pb_q;
    edge_a = mode_select_lo ? a_fall : a_rise; // R13
    edge_b = mode_select_hi ? b_fall : b_rise; // R13
    step = 1'b0;
    if (is_pwm) begin
      step = tick && st_r.run; // R02 R17
    end else if (is_evt) begin
      step = edge_a && st_r.run; // R08 R17
    end else begin
      step = tick; // R12
    end
    uflow = step && (st_r.cnt == timer_pkg::CNT_ZERO);
  end

  // next state of the whole timer
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers, then tick-sampled copies for edge detect
    st_nxt.pa_s1 = timer_pin_a_in;
    st_nxt.pa_s2 = st_r.pa_s1;
    st_nxt.pb_s1 = timer_pin_b;
    st_nxt.pb_s2 = st_r.pb_s1;
    // edge copies follow every cycle until armed, so no false edge after reset
    if (tick || !armed) begin
      st_nxt.pa_q = st_r.pa_s2;
      st_nxt.pb_q = st_r.pb_s2;
    end
    if (!armed) st_nxt.fill = st_r.fill + 2'h1;
    // instruction cycle divider
    st_nxt.div = (st_r.div == DIV_LAST) ? '0 : st_r.div + 1'b1;
    // software writes; hardware updates below take priority
    if (counter_wr) st_nxt.cnt = wr_data;
    if (reload_a_wr) st_nxt.ra = wr_data;
    if (reload_b_wr) st_nxt.rb = wr_data;
    // control bits: clear first so a same-cycle hardware set wins
    if (run_clear) st_nxt.run = 1'b0; // R19
    if (run_set) st_nxt.run = 1'b1; // R19
    if (pending_a_clear) st_nxt.pnd_a = 1'b0; // R06
    if (pending_b_clear) st_nxt.pnd_b = 1'b0; // R06
    // counting
    if (step) st_nxt.cnt = st_r.cnt - timer_pkg::CNT_ONE; // R01
    if (is_pwm) begin
      if (!st_r.run) st_nxt.sel_b = 1'b0; // R03
      if (uflow) begin
        st_nxt.cnt = st_r.sel_b ? st_r.rb : st_r.ra; // R02 R03
        st_nxt.sel_b = !st_r.sel_b; // R03
        if (st_r.sel_b) begin
          st_nxt.pnd_b = 1'b1; // R06
        end else begin
          st_nxt.pnd_a = 1'b1; // R06
        end
        if (mode_select_lo) st_nxt.pin_out = !st_r.pin_out; // R04
      end
      st_nxt.pin_oe_n = 1'b0;
    end else if (is_evt) begin
      st_nxt.sel_b = 1'b0;
      if (uflow) begin
        st_nxt.cnt = st_r.ra;
        st_nxt.pnd_a = 1'b1; // R09
      end
      if (b_rise) st_nxt.pnd_b = 1'b1; // R10
      st_nxt.pin_oe_n = 1'b1; // R11
    end else begin
      st_nxt.sel_b = 1'b0;
      if (uflow) st_nxt.run = 1'b1; // R15
      if (edge_a) begin
        st_nxt.ra = st_r.cnt; // R12
        st_nxt.pnd_a = 1'b1; // R14
      end
      if (edge_b) begin
        st_nxt.rb = st_r.cnt; // R12
        st_nxt.pnd_b = 1'b1; // R14
      end
      st_nxt.pin_oe_n = 1'b1;
    end
    // interrupt requests from enables and pending sources
    st_nxt.irq_a = irq_enable_a && (st_nxt.pnd_a || (is_cap && st_nxt.run)); // R07 R15 R23
    st_nxt.irq_b = irq_enable_b && st_nxt.pnd_b; // R07 R23
  end

  // state register; counter and reload contents are simply cleared too
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r <= '0; // R22
      st_r.pin_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign timer_pin_a_out = st_r.pin_out;
  assign timer_pin_a_oe_n = st_r.pin_oe_n;
  assign counter_value = st_r.cnt;
  assign reload_capture_reg_a = st_r.ra;
  assign reload_capture_reg_b = st_r.rb;
  assign run_or_underflow_bit = st_r.run;
  assign pending_flag_a = st_r.pnd_a;
  assign pending_flag_b = st_r.pnd_b;
  assign irq_a = st_r.irq_a;
  assign irq_b = st_r.irq_b;

  // checks on the timer behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_pwm_reload_a: assert property ( // R03
    (is_pwm && uflow && !st_r.sel_b) |=> (st_r.cnt == $past(st_r.ra)) && st_r.sel_b
  ) else $error("pwm underflow did not reload from register a");

  a_pwm_reload_b: assert property ( // R02
    (is_pwm && uflow && st_r.sel_b) |=> (st_r.cnt == $past(st_r.rb)) && !st_r.sel_b
  ) else $error("pwm underflow did not reload from register b");

  a_pwm_toggle_pin: assert property ( // R04
    (is_pwm && mode_select_lo && uflow) |=> (st_r.pin_out != $past(st_r.pin_out))
  ) else $error("toggle pwm underflow did not invert pin a");

  a_pwm_plain_hold: assert property ( // R04
    (mode == timer_pkg::MODE_PWM_PLAIN) |=> $stable(st_r.pin_out)
  ) else $error("plain pwm changed pin a");

  a_pwm_pend_alt: assert property ( // R06
    (is_pwm && uflow) |=> (st_r.sel_b ? st_r.pnd_a : st_r.pnd_b)
  ) else $error("pwm underflow did not set its pending flag");

  a_evt_pin_idle: assert property ( // R11
    is_evt |=> timer_pin_a_oe_n
  ) else $error("event mode drove pin a");

  a_cap_copy_a: assert property ( // R12
    (is_cap && edge_a) |=> (st_r.ra == $past(st_r.cnt)) && st_r.pnd_a
  ) else $error("capture on pin a failed");

  a_cap_uflow_run: assert property ( // R15
    (is_cap && uflow) |=> st_r.run
  ) else $error("capture underflow did not set run bit");

  a_stop_holds: assert property ( // R17
    (!is_cap && !st_r.run && !counter_wr) |=> $stable(st_r.cnt)
  ) else $error("stopped counter moved");

  a_slow_tick: assert property ( // R20
    (!fast && (st_r.div != '0) && !counter_wr) |=> $stable(st_r.cnt)
  ) else $error("slow rate counter moved between ticks");

  a_irq_b_follow: assert property ( // R23
    (irq_enable_b && st_r.pnd_b && !pending_b_clear) |=> st_r.irq_b
  ) else $error("irq b missing with pending and enable");

  a_irq_a_follow: assert property ( // R23
    (irq_enable_a && st_r.pnd_a && !pending_a_clear) |=> st_r.irq_a
  ) else $error("irq a missing with pending and enable");

  a_pwm_pin_drive: assert property ( // R04
    is_pwm |=> !timer_pin_a_oe_n
  ) else $error("pwm mode left pin a undriven");

  a_pwm_first_a: assert property ( // R03
    (is_pwm && !st_r.run) |=> !st_r.sel_b
  ) else $error("stopped pwm did not return to register a");

  a_evt_count_step: assert property ( // R08
    (is_evt && st_r.run && edge_a && (st_r.cnt != timer_pkg::CNT_ZERO) && !counter_wr)
      |=> (st_r.cnt == $past(st_r.cnt) - timer_pkg::CNT_ONE)
  ) else $error("event edge did not step the counter");

  a_evt_pin_b_pend: assert property ( // R10
    (is_evt && b_rise) |=> st_r.pnd_b
  ) else $error("pin b rise did not set pending b");

  a_cap_copy_b: assert property ( // R12
    (is_cap && edge_b) |=> (st_r.rb == $past(st_r.cnt)) && st_r.pnd_b
  ) else $error("capture on pin b failed");

  c_pwm_both: cover property (is_pwm && uflow && st_r.sel_b);
  c_evt_uflow: cover property (is_evt && uflow);
  c_cap_both: cover property (is_cap && edge_a && edge_b);
  c_cap_wrap: cover property (is_cap && uflow ##1 st_r.irq_a);
  c_evt_pin_b: cover property (is_evt && b_rise);

endmodule : dual_reload_timer_pwm_capture

/* hw/timer_pkg.sv */
// constants shared by the dual reload timer
package timer_pkg;
  localparam int CNT_W = 16;
  // mode select field, {hi, mid, lo}
  localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
  localparam logic [2:0] MODE_PWM_PLAIN = 3'h4;
  localparam logic [2:0] MODE_EVT_RISE = 3'h0;
  localparam logic [2:0] MODE_EVT_FALL = 3'h1;
  localparam logic [2:0] MODE_CAP_RR = 3'h2;
  localparam logic [2:0] MODE_CAP_RF = 3'h6;
  localparam logic [2:0] MODE_CAP_FR = 3'h3;
  localparam logic [2:0] MODE_CAP_FF = 3'h7;
  // field positions inside the mode select field
  localparam int MODE_HI_POS = 2;
  localparam int MODE_MID_POS = 1;
  localparam int MODE_LO_POS = 0;
  // fast clock select is bit 0 of the speed control register
  localparam int FAST_SEL_POS = 0;
  localparam logic [7:0] SPEED_CTL_RESET = 8'h00;
  // timing: mclk 100 MHz, instruction cycle is ten mclk periods
  localparam int MCLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLE_NS = 100;
  localparam int TC_DIV = INSTR_CYCLE_NS / MCLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : timer_pkg

/* tb/tb.sv */
// self-checking bench for the dual reload timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [6:0] stb = 7'h00;
  logic mode_select_hi, mode_select_mid, mode_select_lo;
  logic run_set, run_clear, pending_a_clear, pending_b_clear;
  logic counter_wr, reload_a_wr, reload_b_wr;
  logic irq_enable_a = 1'b0;
  logic irq_enable_b = 1'b0;
  logic [7:0] speed_control_register = 8'h01;
  logic [15:0] wr_data = 16'h0000;
  logic timer_pin_a_in = 1'b0;
  logic timer_pin_b = 1'b0;
  logic timer_pin_a_out, timer_pin_a_oe_n, run_or_underflow_bit;
  logic pending_flag_a, pending_flag_b, irq_a, irq_b, ep;
  logic [15:0] counter_value, reload_capture_reg_a, reload_capture_reg_b, dv;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32;
  int now = 0;
  int t0, k;
  int rv[2];
  int exp_q[$];
  localparam int SLOW_DIV = 2;

  // mode field and one-hot strobes onto the ports
  assign {mode_select_hi, mode_select_mid, mode_select_lo} = mode;
  assign {reload_b_wr, reload_a_wr, counter_wr} = stb[6:4];
  assign {pending_b_clear, pending_a_clear, run_clear, run_set} = stb[3:0];

  dual_reload_timer_pwm_capture #(.SECOND_TIMER(1'b1), .DIV(SLOW_DIV)) u_dual_reload_timer_pwm_capture (
    .mclk, .resetn, .mode_select_hi, .mode_select_mid, .mode_select_lo, .irq_enable_a,
    .irq_enable_b, .speed_control_register, .run_set, .run_clear, .pending_a_clear,
    .pending_b_clear, .counter_wr, .reload_a_wr, .reload_b_wr, .wr_data, .timer_pin_a_in,
    .timer_pin_b, .timer_pin_a_out, .timer_pin_a_oe_n, .counter_value, .reload_capture_reg_a,
    .reload_capture_reg_b, .run_or_underflow_bit, .pending_flag_a, .pending_flag_b, .irq_a,
    .irq_b
  );

  // clock and cycle count
  always #5 mclk = ~mclk;
  always @(posedge mclk) now <= now + 1;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one-cycle strobe: 0 run set, 1 run clear, 2/3 flag clears, 4..6 writes
  task automatic pulse(input int w, input logic [15:0] d);
    @(posedge mclk);
    stb <= 7'h01 << w;
    wr_data <= d;
    @(posedge mclk);
    stb <= 7'h00;
  endtask : pulse

  // pin high then low, each level held long enough for the synchroniser
  task automatic pin_pulse(input int p);
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      if (p) timer_pin_b <= v[0];
      else timer_pin_a_in <= v[0];
      repeat (6) @(posedge mclk);
      @(negedge mclk);
    end
  endtask : pin_pulse

  // bounded wait on falling edges for a pending flag
  task automatic wait_flag(input int b);
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      if ((b ? pending_flag_b : pending_flag_a) === 1'b1) return;
    end
    chk("flag wait", 16'h1, 16'h0);
  endtask : wait_flag

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // watchdog well above the expected run length
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk("reset flags", 16'h0, {14'h0, pending_flag_a, pending_flag_b});
    // random writes land one cycle later
    for (k = 4; k < 7; k++) begin
      dv = $random(seed);
      pulse(k, dv);
      @(negedge mclk);
      chk("write", dv, k == 4 ? counter_value : k == 5 ? reload_capture_reg_a
          : reload_capture_reg_b);
    end
    $display("test registers done");
    // pwm toggle then plain, restarted each pass
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      mode <= m ? timer_pkg::MODE_PWM_PLAIN : timer_pkg::MODE_PWM_TOGGLE;
      speed_control_register <= m ? 8'h00 : 8'h01;
      irq_enable_a <= 1'b1;
      irq_enable_b <= 1'b1;
      rv[0] = 3 + ($random(seed) & 7);
      rv[1] = 3 + ($random(seed) & 7);
      // model: reloads follow a, b, a, b from the first underflow
      for (k = 0; k < 4; k++) exp_q.push_back(rv[k % 2]);
      pulse(5, rv[0][15:0]);
      pulse(6, rv[1][15:0]);
      pulse(4, 16'h0000);
      pulse(2, 16'h0000);
      pulse(3, 16'h0000);
      @(negedge mclk);
      ep = timer_pin_a_out;
      pulse(0, 16'h0000);
      for (k = 0; k < 4; k++) begin
        wait_flag(k % 2);
        if (k > 0) chk("period", 16'((rv[(k + 1) % 2] + 1) * (m ? SLOW_DIV : 1)),
                       16'(now - t0));
        t0 = now;
        ep = ep ^ (m == 0);
        chk("reload", 16'(exp_q.pop_front()), counter_value);
        chk("other flag", 16'h0, {15'h0, (k % 2) ? pending_flag_a : pending_flag_b});
        chk("pin level", {15'h0, ep}, {15'h0, timer_pin_a_out});
        chk("irq", 16'h1, {15'h0, (k % 2) ? irq_b : irq_a});
        chk("drive", 16'h0, {15'h0, timer_pin_a_oe_n});
        pulse(2 + k % 2, 16'h0000);
      end
      pulse(1, 16'h0000);
    end
    $display("test pwm done");
    // event counting on both edge codes, pin b interrupt masked on second pass
    for (int e = 0; e < 2; e++) begin
      @(posedge mclk);
      mode <= e ? timer_pkg::MODE_EVT_FALL : timer_pkg::MODE_EVT_RISE;
      speed_control_register <= e ? 8'h01 : 8'h00;
      irq_enable_b <= (e == 0);
      rv[0] = 1 + ($random(seed) & 3);
      pulse(4, rv[0][15:0]);
      pulse(2, 16'h0000);
      pulse(3, 16'h0000);
      pulse(0, 16'h0000);
      for (k = 0; k <= rv[0]; k++) begin
        chk("flag early", 16'h0, {15'h0, pending_flag_a});
        pin_pulse(0);
        if (k < rv[0]) chk("event count", 16'(rv[0] - k - 1), counter_value);
      end
      chk("underflow flag", 16'h1, {15'h0, pending_flag_a});
      chk("irq a", 16'h1, {15'h0, irq_a});
      chk("no drive", 16'h1, {15'h0, timer_pin_a_oe_n});
      chk("b early", 16'h0, {15'h0, pending_flag_b});
      pin_pulse(1);
      chk("b edge", 16'h1, {15'h0, pending_flag_b});
      chk("irq b", {15'h0, e == 0}, {15'h0, irq_b});
      pulse(1, 16'h0000);
    end
    $display("test event done");
    // capture on every edge code; underflow pends on the run bit
    for (int c = 0; c < 4; c++) begin
      // stop in event mode so the counter write lands, clear run, then enter capture
      @(posedge mclk);
      mode <= timer_pkg::MODE_EVT_RISE;
      speed_control_register <= 8'h01;
      pulse(1, 16'h0000);
      pulse(4, 16'h0002);
      @(posedge mclk);
      mode <= {c[1], 1'b1, c[0]};
      timer_pin_a_in <= c[0];
      timer_pin_b <= c[1];
      repeat (8) @(negedge mclk);
      chk("underflow pend", 16'h1, {15'h0, run_or_underflow_bit});
      chk("underflow irq", 16'h1, {15'h0, irq_a});
      pulse(2, 16'h0000);
      pulse(3, 16'h0000);
      @(posedge mclk);
      timer_pin_a_in <= ~c[0];
      wait_flag(0);
      dv = reload_capture_reg_a - counter_value;
      chk("capture a", 16'h1, {15'h0, dv < 16'h0008});
      chk("b quiet", 16'h0, {15'h0, pending_flag_b});
      @(posedge mclk);
      timer_pin_b <= ~c[1];
      wait_flag(1);
      dv = reload_capture_reg_b - counter_value;
      chk("capture b", 16'h1, {15'h0, dv < 16'h0008});
    end
    $display("test capture done");
    end_of_test();
  end
endmodule : tb
